//--- hdl/deac_defines.svh
// constants for the data eeprom access controller
// assumes inclusion by bare name from hdl/
`ifndef DEAC_DEFINES_SVH
`define DEAC_DEFINES_SVH

// control register bit positions
`define DEAC_CTL_RD_START   0
`define DEAC_CTL_RD_EN      1
`define DEAC_CTL_WR_START   2
`define DEAC_CTL_WR_EN      3
// indirect location of the control register inside bank one
`define DEAC_CTL_LOC        8'h40
`define DEAC_CTL_BANK       1'b1
// reset values
`define DEAC_CTL_RESET      4'h0
`define DEAC_BANK_RESET     1'b0
// read countdown load; the read state lasts this many system clocks plus one
`define DEAC_RD_CYCLES      4'h2

`endif

//--- hdl/deac_pkg.sv
// types for the data eeprom access controller
// assumes deac_defines.svh is compiled alongside
package deac_pkg;
	typedef struct packed {
		logic       we;
		logic [7:0] wdata;
	} deac_wr_t;

	typedef struct packed {
		logic       req;
		logic       we;
		logic [7:0] addr;
		logic [7:0] wdata;
	} deac_mem_req_t;

	typedef enum logic [1:0] {
		DEAC_IDLE,
		DEAC_READ,
		DEAC_WRITE
	} deac_state_t;
endpackage

//--- hdl/deac_top.sv
// data eeprom access controller: address, data and control registers,
// read/write sequencing, read countdown and completion interrupt flag.
// assumes the cpu writes registers with one-cycle strobes and that the
// array answers writes with a done pulse from its own timer.
//
// Behaviour
// RL1: data holding register eight bits, read/write
// RL2: software sets read enable, address, start
// RL3: read start ignored while read enable low
// RL4: read end clears start, loads data
// RL5: data held until next read/write
// RL6: software sets write enable, address, data, start
// RL7: write start ignored while write enable low
// RL8: write timed by asynchronous internal timer
// RL9: write end clears write start bit
// RL10: power-on clears write enable bit
// RL11: bank resets zero; control only bank one
// RL12: cycle end sets interrupt request flag
// RL13: vector needs enables and stack room
// RL14: servicing clears interrupt request flag
// RL15: software keeps write enable, bank cleared
// RL16: software may read back written bytes
// RL17: control reached via pointer 040h, bank one
// RL18: control bits 3..0, upper bits zero
// RL19: no new start while busy
`timescale 1ns/1ps
`default_nettype none
`include "deac_defines.svh"

module deac_top #(
	parameter int unsigned RD_LATENCY = `DEAC_RD_CYCLES
) (
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  wire logic                bank_wr,
	input  wire logic                bank_wdata,
	input  wire logic                pointer_wr,
	input  wire logic [7:0]          pointer_wdata,
	input  wire logic                addr_wr,
	input  wire logic [7:0]          addr_wdata,
	input  wire deac_pkg::deac_wr_t  data_wr,
	input  wire deac_pkg::deac_wr_t  indirect_wr,
	input  wire logic                irq_enable_wr,
	input  wire logic                irq_enable_wdata,
	input  wire logic                flag_wr,
	input  wire logic                flag_wdata,
	input  wire logic                global_irq_en,
	input  wire logic                stack_full,
	input  wire logic                irq_ack,
	input  wire logic [7:0]          mem_rdata,
	input  wire logic                mem_wr_done,
	output logic [7:0]               eeprom_data_holding,
	output logic [7:0]               eeprom_byte_address,
	output logic [7:0]               indirect_access_one,
	output logic                     bank_selector,
	output logic                     eeprom_irq_enable,
	output logic                     eeprom_irq_flag,
	output logic                     irq_request,
	output deac_pkg::deac_mem_req_t  mem_req
);
	import deac_pkg::*;

	// ************************************************
	// register state
	// ************************************************
	logic [7:0]  data_q, data_d;
	logic [7:0]  addr_q, addr_d;
	logic [7:0]  ptr_q, ptr_d;
	logic        bank_q, bank_d;
	logic [3:0]  ctl_q, ctl_d;
	logic        ien_q, ien_d;
	logic        flag_q, flag_d;
	logic        irq_q, irq_d;
	// read countdown in system clocks
	logic [3:0]  cnt_q, cnt_d;
	deac_state_t state_q, state_d;
	deac_mem_req_t mreq_q, mreq_d;
	logic [7:0]  ind_q, ind_d;
	logic        ctl_sel;
	logic        cyc_end;
	logic [3:0]  ctl_w;

	// control visible only with bank one and pointer at its location
	assign ctl_sel = (bank_q == `DEAC_CTL_BANK) && (ptr_q == `DEAC_CTL_LOC); // [RL11] [RL17]

	// ************************************************
	// elaboration checks
	// ************************************************
	// the countdown is four bits; a longer latency needs a wider counter
	// zero is allowed and ends the read in the cycle after the request
	if (RD_LATENCY > 15) begin : g_rd_latency_check
		$error("read latency exceeds the four-bit countdown");
	end

	// ************************************************
	// control, data and sequencing
	// ************************************************
	always_comb begin
		data_d  = data_q;
		addr_d  = addr_wr ? addr_wdata : addr_q;
		ptr_d   = pointer_wr ? pointer_wdata : ptr_q;
		bank_d  = bank_wr ? bank_wdata : bank_q;
		ctl_d   = ctl_q;
		ien_d   = irq_enable_wr ? irq_enable_wdata : ien_q;
		flag_d  = flag_q;
		state_d = state_q;
		cnt_d   = cnt_q;
		mreq_d  = mreq_q;
		mreq_d.req = 1'b0;
		cyc_end = 1'b0;
		ctl_w   = ctl_q;
		if (data_wr.we) begin
			data_d = data_wr.wdata; // [RL1]
		end
		if (indirect_wr.we && ctl_sel) begin
			ctl_w = indirect_wr.wdata[3:0];
			ctl_d[`DEAC_CTL_WR_EN] = ctl_w[`DEAC_CTL_WR_EN];
			ctl_d[`DEAC_CTL_RD_EN] = ctl_w[`DEAC_CTL_RD_EN];
			// start bits cannot be cleared by software mid-cycle; new starts only from idle
			if (state_q == DEAC_IDLE) begin // [RL19]
				ctl_d[`DEAC_CTL_WR_START] = ctl_w[`DEAC_CTL_WR_START] & ctl_q[`DEAC_CTL_WR_EN]; // [RL7]
				ctl_d[`DEAC_CTL_RD_START] = ctl_w[`DEAC_CTL_RD_START] & ctl_q[`DEAC_CTL_RD_EN]
					& ~(ctl_w[`DEAC_CTL_WR_START] & ctl_q[`DEAC_CTL_WR_EN]); // [RL3]
			end
		end
		unique case (state_q)
			DEAC_IDLE: begin
				// write start wins when both are pending
				if (ctl_q[`DEAC_CTL_WR_START]) begin
					state_d      = DEAC_WRITE;
					mreq_d.req   = 1'b1;
					mreq_d.we    = 1'b1;
					mreq_d.addr  = addr_q;
					mreq_d.wdata = data_q;
				end else if (ctl_q[`DEAC_CTL_RD_START]) begin
					state_d     = DEAC_READ;
					cnt_d       = 4'(RD_LATENCY);
					mreq_d.req  = 1'b1;
					mreq_d.we   = 1'b0;
					mreq_d.addr = addr_q;
				end
			end
			DEAC_READ: begin
				// mem_rdata must stand for the whole countdown
				if (cnt_q == 4'h0) begin
					data_d  = mem_rdata; // [RL4] [RL5]
					ctl_d[`DEAC_CTL_RD_START] = 1'b0; // [RL4]
					state_d = DEAC_IDLE;
					cyc_end = 1'b1;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
			DEAC_WRITE: begin
				// done comes from the array's own timer, so the length is not fixed
				if (mem_wr_done) begin // [RL8]
					ctl_d[`DEAC_CTL_WR_START] = 1'b0; // [RL9]
					state_d = DEAC_IDLE;
					cyc_end = 1'b1;
				end
			end
			default: state_d = DEAC_IDLE;
		endcase
		if (flag_wr) begin
			flag_d = flag_wdata;
		end
		if (irq_ack) begin
			flag_d = 1'b0; // [RL14]
		end
		// set wins over any clear in the same cycle
		if (cyc_end) begin
			flag_d = 1'b1; // [RL12]
		end
		// registered, so the request trails the flag by one cycle
		irq_d = flag_q & ien_q & global_irq_en & ~stack_full & ~irq_ack; // [RL13]
		ind_d = ctl_sel ? {4'h0, ctl_d} : 8'h00; // [RL18]
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			// data and address are undefined at power-on; cleared here for determinism
			data_q  <= 8'h00;
			addr_q  <= 8'h00;
			ptr_q   <= 8'h00;
			bank_q  <= `DEAC_BANK_RESET; // [RL11]
			ctl_q   <= `DEAC_CTL_RESET; // [RL10]
			// interrupt state starts quiet so no request follows reset
			ien_q   <= 1'b0;
			flag_q  <= 1'b0;
			irq_q   <= 1'b0;
			cnt_q   <= 4'h0;
			state_q <= DEAC_IDLE;
			mreq_q  <= '0;
			ind_q   <= 8'h00;
		end else begin
			data_q  <= data_d;
			addr_q  <= addr_d;
			ptr_q   <= ptr_d;
			bank_q  <= bank_d;
			ctl_q   <= ctl_d;
			ien_q   <= ien_d;
			flag_q  <= flag_d;
			irq_q   <= irq_d;
			cnt_q   <= cnt_d;
			state_q <= state_d;
			mreq_q  <= mreq_d;
			ind_q   <= ind_d;
		end
	end

	// ************************************************
	// outputs, each straight from its register
	// ************************************************
	assign eeprom_data_holding = data_q;
	assign eeprom_byte_address = addr_q;
	assign indirect_access_one = ind_q;
	assign bank_selector       = bank_q;
	assign eeprom_irq_enable   = ien_q;
	assign eeprom_irq_flag     = flag_q;
	assign irq_request         = irq_q;
	assign mem_req             = mreq_q;
endmodule
`default_nettype wire

//--- testbench/deac_monitor.sv
// port checker for deac_top, one clock domain
// assumes a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module deac_monitor (
	input wire logic			clk,
	input wire logic			reset_n,
	input wire logic			irq_ack,
	input wire logic			mem_wr_done,
	input wire logic			global_irq_en,
	input wire logic			stack_full,
	input wire logic [7:0]			indirect_access_one,
	input wire logic			bank_selector,
	input wire logic			eeprom_irq_enable,
	input wire logic			eeprom_irq_flag,
	input wire logic			irq_request,
	input wire deac_pkg::deac_mem_req_t	mem_req
);
	import deac_pkg::*;
	// control view tracks the register with no lag; starts are gated by the enable held before the write, so gates compare with the cycle before
	logic [7:0]	c;
	assign c = indirect_access_one;
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	property p_rdg; $rose(c[0]) |-> $past(c[1]); endproperty
	a_rdg: assert property (p_rdg) else $error("read start ungated");
	property p_wrg; $rose(c[2]) |-> $past(c[3]); endproperty
	a_wrg: assert property (p_wrg) else $error("write start ungated");
	property p_rdend; mem_req.req && !mem_req.we |-> ##[1:8] !c[0] && eeprom_irq_flag; endproperty
	a_rdend: assert property (p_rdend) else $error("read end late");
	property p_wrend; mem_wr_done |-> ##[1:3] !c[2] && eeprom_irq_flag; endproperty
	a_wrend: assert property (p_wrend) else $error("write end late");
	property p_irq; irq_request |-> $past(eeprom_irq_flag && eeprom_irq_enable && global_irq_en && !stack_full); endproperty
	a_irq: assert property (p_irq) else $error("bad request");
	property p_ack; irq_ack |=> !eeprom_irq_flag || $fell(c[0]) || $fell(c[2]); endproperty
	a_ack: assert property (p_ack) else $error("flag kept");
	property p_por; $rose(reset_n) |-> !bank_selector && c == 8'h00 && !eeprom_irq_flag; endproperty
	a_por: assert property (p_por) else $error("bad reset state");
	property p_upper; c[7:4] == 4'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
// self-checking bench for deac_top
// assumes deac_pkg and deac_monitor compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import deac_pkg::*;
	logic		clk = '0, reset_n = '0, bank_wr = '0, bank_wdata = '0, pointer_wr = '0, addr_wr = '0, flag_wr = '0;
	logic		irq_enable_wr = '0, irq_enable_wdata = '0, flag_wdata = '0, global_irq_en = '0, stack_full = '0;
	logic		irq_ack = '0, mem_wr_done = '0, bank_selector, eeprom_irq_enable, eeprom_irq_flag, irq_request;
	logic [7:0]	pointer_wdata = '0, addr_wdata = '0, mem_rdata = '0, a, d, r;
	logic [7:0]	eeprom_data_holding, eeprom_byte_address, indirect_access_one;
	deac_wr_t	data_wr = '0, indirect_wr = '0;
	deac_mem_req_t	mem_req, seen = '0;
	int		failures = 0, total_checks = 0, i;
	integer		seed = 64364;
	deac_top i_deac_top (.*);
	always #5 clk = ~clk;
	// req is a one-cycle pulse, so keep the last one for later comparison
	always @(posedge clk) if (mem_req.req === 1'h1) seen <= mem_req;
	task automatic final_report();
		if (failures == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: mismatch %h", $time, got);
		end
	endtask
	// expected request: flag raised, both enables on, stack not full
	function automatic logic exp_irq(input logic ien, input logic glob, input logic full);
		return ien & glob & ~full;
	endfunction
	// idle cycle after each strobe so no strobe is driven twice in one step
	task automatic wreg(input int k, input logic [7:0] v);
		{bank_wdata, pointer_wdata, addr_wdata, data_wr.wdata, indirect_wr.wdata} = {v[0], v, v, v, v};
		{irq_enable_wdata, flag_wdata} = {v[0], v[0]};
		{flag_wr, irq_enable_wr, indirect_wr.we, data_wr.we, addr_wr, pointer_wr, bank_wr} = 7'h01 << k;
		@(posedge clk) #1;
		{flag_wr, irq_enable_wr, indirect_wr.we, data_wr.we, addr_wr, pointer_wr, bank_wr} = 7'h00;
		@(posedge clk) #1;
	endtask
	task automatic wt(input int s);
		int n;
		for (n = 0; n < 60 && indirect_access_one[s] !== 1'h0; n++) @(posedge clk) #1;
		if (n == 60) begin
			$display("Error %0t: wait for start bit timed out", $time);
			failures++;
			final_report();
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1 reset_n = '1;
		@(posedge clk) #1;
		chk({bank_selector, eeprom_irq_flag, indirect_access_one}, 18'h0);
		wreg(1, 8'h40);
		wreg(4, 8'h0a);
		wreg(0, 8'h01);
		chk(indirect_access_one, 18'h0);
		wreg(4, 8'hff);
		chk({seen.req, indirect_access_one}, 18'h0a);
		wreg(5, 8'h01);
		chk(eeprom_irq_enable, 18'h1);
		global_irq_en = '1;
		for (i = 0; i < 8; i++) begin
			{a, d, r} = 24'($random(seed));
			if (i == 0) {a, d} = 16'hff00;
			stack_full = r[0];
			wreg(2, a);
			chk(eeprom_byte_address, a);
			wreg(3, d);
			wreg(4, 8'h0e);
			repeat (r[3:1]) @(posedge clk) #1;
			mem_wr_done = '1;
			@(posedge clk) #1 mem_wr_done = '0;
			wt(2);
			chk({seen.we, eeprom_irq_flag, seen.addr, seen.wdata}, {2'h3, a, d});
			// the request is registered, so it trails the flag by a cycle
			@(posedge clk) #1;
			chk(irq_request, exp_irq(1'b1, global_irq_en, r[0]));
			irq_ack = '1;
			@(posedge clk) #1 irq_ack = '0;
			chk(eeprom_irq_flag, 1'h0);
			mem_rdata = r;
			wreg(4, 8'h0b);
			wt(0);
			chk({seen.we, eeprom_irq_flag, seen.addr, eeprom_data_holding}, {2'h1, a, r});
			mem_rdata = ~r;
			wreg(6, 8'h00);
			chk({eeprom_irq_flag, eeprom_data_holding}, {1'h0, r});
		end
		// reset again while write enable is still set from the last read
		reset_n = '0;
		@(posedge clk) #1 reset_n = '1;
		@(posedge clk) #1;
		chk({bank_selector, eeprom_irq_enable, eeprom_irq_flag, irq_request}, 18'h0);
		wreg(1, 8'h40);
		wreg(0, 8'h01);
		chk(indirect_access_one, 18'h0);
		wreg(0, 8'h00);
		chk({bank_selector, indirect_access_one}, 18'h0);
		final_report();
	end
endmodule
bind deac_top deac_monitor i_deac_monitor (.*);
`default_nettype wire
